// [dv/fspr_checker.sv]
// Assertion checker for the fault reaction unit
`timescale 1ns/1ps
module fspr_checker import fspr_pkg::*; #(
  parameter int TICK_CYCLES = 4,
  parameter int PERSIST_SECONDS = 3
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  // Diagnostics
  input wire fspr_pkg::fspr_diag_type diag_in,
  input wire fspr_pkg::fspr_event_type event_in,
  // Outputs watched
  input wire logic [fspr_pkg::CHANNELS-1:0] input_value_out,
  input wire logic [fspr_pkg::CHANNELS-1:0] output_drive_out,
  input wire logic [fspr_pkg::CHANNELS-1:0] passive_out,
  input wire logic reintegration_request_out
);
  localparam int LOCK_LIMIT = TICK_CYCLES * (PERSIST_SECONDS + 1) + 8;
  logic [31:0] run_reg;
  logic act0_reg;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // Cycles that channel 0 has stayed passivated
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_reg <= '0;
    end else if (passive_out[0]) begin
      run_reg <= run_reg + 32'h1;
    end else begin
      run_reg <= '0;
    end
  end

  // Activation of channel 0 as written by software
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act0_reg <= ACTIVE_RESET[0];
    end else if (reg_write_in && reg_addr_in == ACTIVE_OFFSET) begin
      act0_reg <= reg_wdata_in[0];
    end
  end

  sequence seq_ack;
    reintegration_request_out && reg_write_in && reg_addr_in == CTRL_OFFSET && reg_wdata_in[CTRL_ACK_BIT];
  endsequence

  sequence seq_released;
    !reintegration_request_out;
  endsequence

  AST_IN_SAFE: assert property ((input_value_out & passive_out) == '0)
    else $error("passivated input reports nonzero");
  AST_OUT_SAFE: assert property ((output_drive_out & passive_out) == '0)
    else $error("passivated output driven");
  AST_TIMEOUT: assert property (event_in.comm_timeout |=> passive_out == 8'hff)
    else $error("time-out did not passivate all");
  AST_MOD_FAULT: assert property (event_in.module_fault || event_in.fatal_fault |=> &passive_out)
    else $error("module fault did not passivate all");
  AST_CHAN: assert property (act0_reg && diag_in.chan_fault[0] |=> passive_out[0])
    else $error("channel fault did not passivate channel");
  AST_SWITCH: assert property (act0_reg && (diag_in.switch_a_fault[0] || diag_in.switch_b_fault[0]) |=> passive_out[0])
    else $error("switch fault did not passivate channel");
  AST_ACK: assert property (seq_ack |-> ##2 seq_released)
    else $error("request stayed after acknowledge");
  AST_REQ_PASSIVE: assert property (reintegration_request_out |-> passive_out != '0)
    else $error("request without a waiting channel");
  AST_LOCK: assert property (run_reg >= LOCK_LIMIT |-> passive_out == 8'hff)
    else $error("persistent passivation did not lock module");
endmodule

bind fspr_top fspr_checker #(.TICK_CYCLES(TICK_CYCLES), .PERSIST_SECONDS(PERSIST_SECONDS)) fspr_checker_inst (
  .clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .diag_in(diag_in), .event_in(event_in), .input_value_out(input_value_out),
  .output_drive_out(output_drive_out), .passive_out(passive_out),
  .reintegration_request_out(reintegration_request_out));

// [dv/fspr_ctrl_model.sv]
// Safety controller model: master of the register port
`timescale 1ns/1ps
module fspr_ctrl_model (
  // Clock
  input wire logic clock_in,
  // Answers from the block
  input wire logic [31:0] reg_rdata_in,
  input wire logic request_in,
  // Register port
  output logic [7:0] reg_addr_out,
  output logic [31:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out
);
  import fspr_pkg::*;

  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 32'h0;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_write_out <= 1'b1;
    @(posedge clock_in);
    reg_write_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_read_out <= 1'b1;
    @(posedge clock_in);
    reg_read_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask

  // Acknowledge is only sent while the request flag stands
  task automatic ack(input logic [31:0] ctrl, output logic sent);
    sent = request_in;
    if (request_in) begin
      wr(CTRL_OFFSET, ctrl | (32'h1 << CTRL_ACK_BIT));
    end
  endtask
endmodule

// [dv/fspr_tb_top.sv]
// Testbench for the fault reaction unit
`timescale 1ns/1ps
module fspr_tb_top;
  import fspr_pkg::*;
  localparam int TICKS = 10;
  localparam int SECS = 50;
  logic clock_in;
  logic resetn_in;
  fspr_diag_type diag;
  fspr_event_type evt;
  logic grp;
  logic [7:0] field;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [31:0] rdata;
  logic [7:0] iv;
  logic [7:0] od;
  logic [7:0] pv;
  logic req;
  logic [31:0] d;
  logic sent;
  int n_errors;
  int compares;

  fspr_top #(.TICK_CYCLES(TICKS), .PERSIST_SECONDS(SECS)) fspr_top_inst (.clock_in(clock_in),
    .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_rdata_out(rdata), .diag_in(diag), .event_in(evt), .group_acknowledge_input_in(grp),
    .field_input_in(field), .input_value_out(iv), .output_drive_out(od), .passive_out(pv),
    .reintegration_request_out(req));
  fspr_ctrl_model fspr_ctrl_model_inst (.clock_in(clock_in), .reg_rdata_in(rdata), .request_in(req),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_write_out(wr_s), .reg_read_out(rd_s));

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    fspr_ctrl_model_inst.rd(a, d);
    chk("register", exp, d);
  endtask

  task automatic hit(input fspr_diag_type v, input logic [7:0] exp);
    @(posedge clock_in);
    diag <= v;
    cyc(2);
    chk("passive", exp, pv);
  endtask

  task automatic pulse(input fspr_event_type e);
    @(posedge clock_in);
    evt <= e;
    @(posedge clock_in);
    evt <= 4'h0;
    cyc(2);
  endtask

  task automatic group_ack();
    @(posedge clock_in);
    grp <= 1'b1;
    repeat (5) @(posedge clock_in);
    grp <= 1'b0;
    #1;
  endtask

  task automatic wait_pv(input logic [7:0] exp, input int bound);
    for (int i = 0; i < bound && pv !== exp; i++) begin
      @(posedge clock_in);
      #1;
    end
    if (pv !== exp) begin
      $display("BAD wait passive expected %h seen %h", exp, pv);
      n_errors++;
      close_out();
    end
  endtask

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  initial begin
    n_errors = 0;
    compares = 0;
    resetn_in = 1'b0;
    diag = '0;
    evt = '0;
    grp = 1'b0;
    field = 8'ha5;
    repeat (16) @(posedge clock_in);
    resetn_in <= 1'b1;
    cyc(1);
    chk("passive", PASSIVE_RESET, pv);
    chk("inval", 32'h0, iv);
    rdchk(STATUS_OFFSET, 32'h1 << STAT_STOP_BIT);
    rdchk(CTRL_OFFSET, 32'h1 << CTRL_STOP_BIT);
    rdchk(ACTIVE_OFFSET, 32'(ACTIVE_RESET));
    rdchk(8'h24, 32'h0);
    fspr_ctrl_model_inst.wr(AUTO_OFFSET, 32'h0f);
    fspr_ctrl_model_inst.wr(PAIR_OFFSET, 32'h4);
    fspr_ctrl_model_inst.wr(OUTCMD_OFFSET, 32'hff);
    fspr_ctrl_model_inst.wr(CTRL_OFFSET, 32'h1);
    wait_pv(8'h00, 10);
    cyc(4);
    chk("inval", 32'ha5, iv);
    chk("drive", 32'hff, od);
    fspr_ctrl_model_inst.wr(CTRL_OFFSET, 32'h3);
    cyc(2);
    chk("drive stop", 32'h0, od);
    fspr_ctrl_model_inst.wr(CTRL_OFFSET, 32'h1);
    fspr_ctrl_model_inst.wr(ACTIVE_OFFSET, 32'h7f);
    hit(24'h800000, 8'h00);
    hit(24'h010000, 8'h01);
    chk("drive", 32'hfe, od);
    chk("inval", 32'ha4, iv);
    hit(24'h000000, 8'h00);
    hit(24'h000100, 8'h01);
    hit(24'h000000, 8'h00);
    hit(24'h000040, 8'h40);
    hit(24'h000000, 8'h40);
    cyc(1);
    chk("request", 32'h1, req);
    group_ack();
    chk("passive", 32'h0, pv);
    hit(24'h200000, 8'h30);
    hit(24'h000000, 8'h30);
    cyc(1);
    chk("request", 32'h1, req);
    fspr_ctrl_model_inst.ack(32'h1, sent);
    chk("sent", 32'h1, sent);
    cyc(2);
    chk("passive", 32'h0, pv);
    chk("request", 32'h0, req);
    pulse(4'h2);
    chk("passive", 32'hff, pv);
    cyc(4);
    chk("passive", 32'hff, pv);
    fspr_ctrl_model_inst.ack(32'h1, sent);
    chk("sent", 32'h1, sent);
    cyc(2);
    chk("passive", 32'h0, pv);
    pulse(4'hc);
    chk("passive", 32'hff, pv);
    fspr_ctrl_model_inst.ack(32'h1, sent);
    chk("sent", 32'h0, sent);
    group_ack();
    chk("passive", 32'hff, pv);
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    cyc(1);
    rdchk(STATUS_OFFSET, 32'h1 << STAT_STOP_BIT);
    fspr_ctrl_model_inst.wr(CTRL_OFFSET, 32'h1);
    wait_pv(8'h00, 10);
    hit(24'h010000, 8'h01);
    wait_pv(8'hff, TICKS * (SECS + 2) + 20);
    fspr_ctrl_model_inst.rd(STATUS_OFFSET, d);
    chk("lockout", 32'h1, d[STAT_LOCK_BIT]);
    hit(24'h000000, 8'hff);
    cyc(16);
    chk("passive", 32'hff, pv);
    close_out();
  end
endmodule

// [hw/fspr_persist_timer.sv]
// Continuous passivation timer for one channel
`timescale 1ns/1ps
module fspr_persist_timer #(
  parameter int PERSIST_SECONDS = fspr_pkg::PERSIST_SECONDS_DEF
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Control
  input wire logic tick_in,
  input wire logic passive_in,
  // Result
  output logic expired_out
);
  import fspr_pkg::*;

  localparam logic [PERSIST_WIDTH-1:0] LIMIT = PERSIST_WIDTH'(PERSIST_SECONDS);

  logic [PERSIST_WIDTH-1:0] count_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= '0;
    end else if (!passive_in) begin
      count_reg <= '0; // see RULE21
    end else if (tick_in && count_reg != LIMIT) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= passive_in && (count_reg == LIMIT); // see RULE16
    end
  end

endmodule

// [hw/fspr_pkg.sv]
// Package with constants and types for the fail-safe passivation and reintegration block
package fspr_pkg;

  localparam int CHANNELS = 8;
  localparam int PAIRS = CHANNELS / 2;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] ACTIVE_OFFSET = 8'h04;
  localparam logic [7:0] AUTO_OFFSET = 8'h08;
  localparam logic [7:0] PAIR_OFFSET = 8'h0c;
  localparam logic [7:0] OUTCMD_OFFSET = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;
  localparam logic [7:0] PASSIVE_OFFSET = 8'h18;
  localparam logic [7:0] READY_OFFSET = 8'h1c;
  localparam logic [7:0] INVAL_OFFSET = 8'h20;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;

  // Status register fields
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_FATAL_BIT = 2;
  localparam int STAT_COMM_BIT = 3;
  localparam int STAT_START_BIT = 4;
  localparam int STAT_STOP_BIT = 5;

  // Reset values
  localparam logic [CHANNELS-1:0] ACTIVE_RESET = 8'hff;
  localparam logic [CHANNELS-1:0] AUTO_RESET = 8'h00;
  localparam logic [PAIRS-1:0] PAIR_RESET = 4'h0;
  localparam logic [CHANNELS-1:0] OUTCMD_RESET = 8'h00;
  localparam logic [CHANNELS-1:0] PASSIVE_RESET = 8'hff;
  localparam logic [CHANNELS-1:0] SAFE_VALUE = 8'h00;

  // Timing
  localparam longint CLOCK_HZ = 64'd100_000_000;
  localparam longint SECOND_NS = 64'd1_000_000_000;
  localparam longint CLOCK_PERIOD_NS = SECOND_NS / CLOCK_HZ;
  localparam int TICK_CYCLES_DEF = int'(SECOND_NS / CLOCK_PERIOD_NS);
  localparam int REPAIR_HOURS = 100;
  localparam int SECONDS_PER_HOUR = 3600;
  localparam int PERSIST_SECONDS_DEF = REPAIR_HOURS * SECONDS_PER_HOUR;
  localparam int TICK_WIDTH = 27;
  localparam int PERSIST_WIDTH = 20;

  // Diagnostic results for each channel
  typedef struct packed {
    logic [CHANNELS-1:0] chan_fault;
    logic [CHANNELS-1:0] switch_a_fault;
    logic [CHANNELS-1:0] switch_b_fault;
  } fspr_diag_type;

  // Module-wide diagnostic and communication events
  typedef struct packed {
    logic module_fault;
    logic fatal_fault;
    logic comm_timeout;
    logic comm_error;
  } fspr_event_type;

endpackage

// [hw/fspr_top.sv]
// Fault reaction unit: channel passivation, reintegration and persistence lockout
// How it works
// RULE1 - Passivated input channels report 0 to the safety program.
// RULE2 - Passivated output channels drive 0, ignoring the commanded value.
// RULE3 - Passivation and stop-mode output values are fixed 0, never selectable.
// RULE4 - Channel faults passivate one channel; module faults passivate all.
// RULE5 - Message monitoring time-out passivates every channel.
// RULE6 - Single inputs passivate alone; paired inputs passivate both of the pair.
// RULE7 - Either switching element failing passivates the whole output channel.
// RULE8 - Auto or manual reintegration per channel; communication faults always manual.
// RULE9 - Automatic channels reintegrate at once when their fault clears.
// RULE10 - Request flag rises when a manual channel is cleared and ready.
// RULE11 - Acknowledge only after request; then all ready channels reintegrate.
// RULE12 - Group acknowledge input acknowledges pending faults of the whole group.
// RULE13 - Fatal faults ignore acknowledge; only power cycle clears them.
// RULE14 - Reintegration allowed only after diagnostics show the fault cleared.
// RULE15 - Reintegrated channels pass live inputs and commanded outputs again.
// RULE16 - Passivation lasting 100 hours passivates the module until power cycle.
// RULE17 - Deactivated channels are not diagnosed and raise no faults.
// RULE18 - All channels start passivated until start-up allows operation.
// RULE19 - No fault state survives a power cycle; diagnostics rediscover faults.
// RULE20 - Request flag falls once no channel awaits acknowledged reintegration.
// RULE21 - Passivation timer restarts from zero on reintegration.
`timescale 1ns/1ps
module fspr_top #(
  parameter int TICK_CYCLES = fspr_pkg::TICK_CYCLES_DEF,
  parameter int PERSIST_SECONDS = fspr_pkg::PERSIST_SECONDS_DEF
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Diagnostics
  input wire fspr_pkg::fspr_diag_type diag_in,
  input wire fspr_pkg::fspr_event_type event_in,
  // Group acknowledge pin
  input wire logic group_acknowledge_input_in,
  // Process signals
  input wire logic [fspr_pkg::CHANNELS-1:0] field_input_in,
  output logic [fspr_pkg::CHANNELS-1:0] input_value_out,
  output logic [fspr_pkg::CHANNELS-1:0] output_drive_out,
  // Status
  output logic [fspr_pkg::CHANNELS-1:0] passive_out,
  output logic reintegration_request_out
);
  import fspr_pkg::*;

  localparam logic [TICK_WIDTH-1:0] TICK_LAST = TICK_WIDTH'(TICK_CYCLES - 1);

  // Spread a per-pair flag over both channels of the pair
  function automatic logic [CHANNELS-1:0] pair_expand(input logic [PAIRS-1:0] pairs);
    logic [CHANNELS-1:0] result;
    result = '0;
    for (int p = 0; p < PAIRS; p++) begin
      result[2*p] = pairs[p];
      result[2*p+1] = pairs[p];
    end
    return result;
  endfunction

  // Swap the two channels within each pair
  function automatic logic [CHANNELS-1:0] pair_swap(input logic [CHANNELS-1:0] value);
    logic [CHANNELS-1:0] result;
    result = '0;
    for (int p = 0; p < PAIRS; p++) begin
      result[2*p] = value[2*p+1];
      result[2*p+1] = value[2*p];
    end
    return result;
  endfunction

  // Configuration and control registers
  logic start_reg;
  logic stop_reg;
  logic [CHANNELS-1:0] active_reg;
  logic [CHANNELS-1:0] auto_reg;
  logic [PAIRS-1:0] pair_reg;
  logic [CHANNELS-1:0] outcmd_reg;
  logic sw_ack_reg;

  // Fault reaction state
  logic [CHANNELS-1:0] passive_reg;
  logic [CHANNELS-1:0] passive_next;
  logic comm_pending_reg;
  logic fatal_reg;
  logic lockout_reg;
  logic started_reg;
  logic req_reg;

  // Pin synchronisers
  logic [CHANNELS-1:0] field_meta_reg;
  logic [CHANNELS-1:0] field_sync_reg;
  logic gack_meta_reg;
  logic gack_sync_reg;
  logic gack_prev_reg;

  // Persistence tick divider
  logic [TICK_WIDTH-1:0] tick_count_reg;
  logic tick_reg;
  logic [CHANNELS-1:0] expired;

  // Combinational fault view
  logic [CHANNELS-1:0] raw_fault;
  logic [CHANNELS-1:0] chan_fault;
  logic module_hold;
  logic [CHANNELS-1:0] ready;
  logic [CHANNELS-1:0] manual_ready;
  logic ack_event;
  logic accept_ack;
  logic write_ctrl;

  assign write_ctrl = reg_write_in && (reg_addr_in == CTRL_OFFSET);

  // Deactivated channels contribute no fault; either switch element faults the channel
  assign raw_fault = active_reg & (diag_in.chan_fault | diag_in.switch_a_fault
                                   | diag_in.switch_b_fault); // see RULE7 see RULE17

  // A paired channel also takes its partner's fault
  assign chan_fault = raw_fault | (pair_expand(pair_reg) & pair_swap(raw_fault)); // see RULE6

  // Conditions that hold every channel passivated
  assign module_hold = event_in.module_fault || event_in.fatal_fault || event_in.comm_timeout || event_in.comm_error
                       || fatal_reg || lockout_reg || !start_reg; // see RULE4 see RULE5 see RULE18

  // Channel ready when its passivation cause is gone
  assign ready = module_hold ? '0 : (passive_reg & ~chan_fault); // see RULE14 see RULE13

  // Channels waiting for an acknowledge
  assign manual_ready = comm_pending_reg ? ready : (ready & ~auto_reg); // see RULE8

  // Acknowledge from software or from the group pin
  assign ack_event = sw_ack_reg || (gack_sync_reg && !gack_prev_reg); // see RULE12
  assign accept_ack = ack_event && req_reg; // see RULE11

  // Field input synchroniser
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      field_meta_reg <= '0;
      field_sync_reg <= '0;
    end else begin
      field_meta_reg <= field_input_in;
      field_sync_reg <= field_meta_reg;
    end
  end

  // Group acknowledge synchroniser and edge history
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gack_meta_reg <= 1'b0;
      gack_sync_reg <= 1'b0;
      gack_prev_reg <= 1'b0;
    end else begin
      gack_meta_reg <= group_acknowledge_input_in;
      gack_sync_reg <= gack_meta_reg;
      gack_prev_reg <= gack_sync_reg;
    end
  end

  // Configuration registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_reg <= 1'b0;
      stop_reg <= 1'b1;
      active_reg <= ACTIVE_RESET;
      auto_reg <= AUTO_RESET;
      pair_reg <= PAIR_RESET;
      outcmd_reg <= OUTCMD_RESET;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        CTRL_OFFSET: begin
          start_reg <= reg_wdata_in[CTRL_START_BIT];
          stop_reg <= reg_wdata_in[CTRL_STOP_BIT];
        end
        ACTIVE_OFFSET: active_reg <= reg_wdata_in[CHANNELS-1:0];
        AUTO_OFFSET: auto_reg <= reg_wdata_in[CHANNELS-1:0];
        PAIR_OFFSET: pair_reg <= reg_wdata_in[PAIRS-1:0];
        OUTCMD_OFFSET: outcmd_reg <= reg_wdata_in[CHANNELS-1:0];
        default: begin
        end
      endcase
    end
  end

  // Acknowledge bit acts for one cycle only
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sw_ack_reg <= 1'b0;
    end else begin
      sw_ack_reg <= write_ctrl && reg_wdata_in[CTRL_ACK_BIT];
    end
  end

  // Start-up release happens once
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      started_reg <= 1'b0;
    end else if (start_reg) begin
      started_reg <= 1'b1;
    end
  end

  // Communication fault pending until acknowledged; a new error wins over the clear
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      comm_pending_reg <= 1'b0;
    end else if (event_in.comm_timeout || event_in.comm_error) begin
      comm_pending_reg <= 1'b1; // see RULE8
    end else if (accept_ack) begin
      comm_pending_reg <= 1'b0;
    end
  end

  // Fatal fault latch, cleared by reset only
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fatal_reg <= 1'b0; // see RULE19
    end else if (event_in.fatal_fault) begin
      fatal_reg <= 1'b1; // see RULE13
    end
  end

  // Persistence lockout, cleared by reset only
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lockout_reg <= 1'b0;
    end else if (|expired) begin
      lockout_reg <= 1'b1; // see RULE16
    end
  end

  // One-second tick for the persistence timers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_count_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_count_reg == TICK_LAST) begin
      tick_count_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_count_reg <= tick_count_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  for (genvar i = 0; i < CHANNELS; i++) begin : g_timer
    fspr_persist_timer #(
      .PERSIST_SECONDS(PERSIST_SECONDS)
    ) u_timer (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .tick_in(tick_reg),
      .passive_in(passive_reg[i]),
      .expired_out(expired[i])
    );
  end

  // Passivation next state
  always_comb begin
    passive_next = passive_reg;
    if (!started_reg && start_reg) begin
      passive_next = passive_reg & ~ready; // see RULE18
    end else begin
      passive_next = passive_reg & ~(ready & ~manual_ready); // see RULE9
      if (accept_ack) begin
        passive_next = passive_next & ~ready; // see RULE11
      end
    end
    if (module_hold) begin
      passive_next = '1; // see RULE4 see RULE5
    end
    passive_next = passive_next | chan_fault; // see RULE4 see RULE6
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      passive_reg <= PASSIVE_RESET; // see RULE18
    end else begin
      passive_reg <= passive_next;
    end
  end

  // Reintegration request follows channels awaiting acknowledge
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_reg <= 1'b0;
    end else if (accept_ack) begin
      req_reg <= 1'b0; // see RULE20
    end else begin
      req_reg <= started_reg && (|manual_ready); // see RULE10 see RULE20
    end
  end

  // Process outputs
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      input_value_out <= SAFE_VALUE;
      output_drive_out <= SAFE_VALUE;
    end else begin
      input_value_out <= field_sync_reg & ~passive_next; // see RULE1 see RULE15
      output_drive_out <= stop_reg ? SAFE_VALUE : (outcmd_reg & ~passive_next); // see RULE2 see RULE3 see RULE15
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      passive_out <= PASSIVE_RESET;
      reintegration_request_out <= 1'b0;
    end else begin
      passive_out <= passive_next;
      reintegration_request_out <= (accept_ack ? 1'b0 : (started_reg && (|manual_ready)));
    end
  end

  // Register read port
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      reg_rdata_out <= '0;
      case (reg_addr_in)
        CTRL_OFFSET: begin
          reg_rdata_out[CTRL_START_BIT] <= start_reg;
          reg_rdata_out[CTRL_STOP_BIT] <= stop_reg;
        end
        ACTIVE_OFFSET: reg_rdata_out[CHANNELS-1:0] <= active_reg;
        AUTO_OFFSET: reg_rdata_out[CHANNELS-1:0] <= auto_reg;
        PAIR_OFFSET: reg_rdata_out[PAIRS-1:0] <= pair_reg;
        OUTCMD_OFFSET: reg_rdata_out[CHANNELS-1:0] <= outcmd_reg;
        STATUS_OFFSET: begin
          reg_rdata_out[STAT_REQ_BIT] <= req_reg;
          reg_rdata_out[STAT_LOCK_BIT] <= lockout_reg;
          reg_rdata_out[STAT_FATAL_BIT] <= fatal_reg;
          reg_rdata_out[STAT_COMM_BIT] <= comm_pending_reg;
          reg_rdata_out[STAT_START_BIT] <= started_reg;
          reg_rdata_out[STAT_STOP_BIT] <= stop_reg;
        end
        PASSIVE_OFFSET: reg_rdata_out[CHANNELS-1:0] <= passive_reg;
        READY_OFFSET: reg_rdata_out[CHANNELS-1:0] <= ready;
        INVAL_OFFSET: reg_rdata_out[CHANNELS-1:0] <= input_value_out;
        default: begin
        end
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule
